// ---- hdl/flash_host_pkg.sv ----
// package of constants for the flash command host
// assumes a parallel nor flash on the far side, pins synchronous to pclk
// Behaviour
// - during guard program or erase poll toggle bit; then 00h pass program, 01h pass erase
// - auto-select address 03h shows secure lock on indicator bit
// - auto-select is AA/555, 55/2AA, 90/555; F0 resets; verify at X02
// - secure entry unlock plus 88; exit unlock, 90, then 00
package flash_host_pkg;
  // ******************************
  // register map (apb byte offsets)
  // ******************************
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_WDATA = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_RDATA = 12'h010;
  localparam logic [11:0] OFS_MODE = 12'h014;
  // ******************************
  // command codes and bus words
  // ******************************
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_RESET = 4'h2;
  localparam logic [3:0] OP_AUTOSEL = 4'h3;
  localparam logic [3:0] OP_SEC_ENTER = 4'h4;
  localparam logic [3:0] OP_SEC_EXIT = 4'h5;
  localparam logic [3:0] OP_WRITE = 4'h6;
  localparam logic [3:0] OP_POLL = 4'h7;
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [7:0] D_SECURE = 8'h88;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [7:0] D_EXIT = 8'h00;
  localparam logic [7:0] ST_PROG_OK = 8'h00;
  localparam logic [7:0] ST_ERASE_OK = 8'h01;
  localparam logic [11:0] A_CMD_W = 12'h555;
  localparam logic [11:0] A_UNL_W = 12'h2aa;
  localparam logic [11:0] A_CMD_B = 12'haaa;
  localparam logic [11:0] A_UNL_B = 12'h555;
  localparam logic [7:0] A_SEC_LOCK_W = 8'h03;
  localparam logic [7:0] A_SEC_LOCK_B = 8'h06;
  localparam logic [7:0] A_VERIFY_W = 8'h02;
  localparam logic [7:0] A_VERIFY_B = 8'h04;
  localparam int TOGGLE_BIT = 6;
  localparam int INDICATOR_BIT = 7;
  localparam int SECURE_WORDS = 128;
  localparam int SERIAL_WORDS = 8;
  // ******************************
  // bus timing in cycles
  // ******************************
  localparam int PCLK_MHZ = 25;
  localparam int T_PULSE_NS = 70;
  localparam int PULSE_CYC = (T_PULSE_NS * PCLK_MHZ + 999) / 1000;
  localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SETUP = 3'b001, S_STROBE = 3'b011, S_HOLD = 3'b010,
    S_NEXT = 3'b110, S_DONE = 3'b111
  } seq_state_t;
endpackage

// ---- hdl/seq_rom.sv ----
// holds the bus-cycle tables of each command sequence
// assumes a stable op and index; data registered one cycle later
`timescale 1ns/1ps
`default_nettype none
module seq_rom (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [3:0] op,
  input wire logic [2:0] idx,
  input wire logic byte_mode,
  input wire logic [23:0] user_addr,
  input wire logic [15:0] user_data,
  output logic [23:0] addr_r,
  output logic [15:0] data_r,
  output logic write_r,
  output logic last_r
);
  logic [23:0] a_cmd;
  logic [23:0] a_unl;
  logic [23:0] a_nxt;
  logic [15:0] d_nxt;
  logic w_nxt;
  logic l_nxt;
  assign a_cmd = byte_mode ? {12'h000, flash_host_pkg::A_CMD_B} : {12'h000, flash_host_pkg::A_CMD_W};
  assign a_unl = byte_mode ? {12'h000, flash_host_pkg::A_UNL_B} : {12'h000, flash_host_pkg::A_UNL_W};
  always_comb begin
    a_nxt = user_addr;
    d_nxt = user_data;
    w_nxt = 1'b1;
    l_nxt = 1'b1;
    if ((op == flash_host_pkg::OP_AUTOSEL || op == flash_host_pkg::OP_SEC_ENTER ||
         op == flash_host_pkg::OP_SEC_EXIT) && idx < 3'd3) begin
      l_nxt = 1'b0;
      unique case (idx)
        3'd0: begin
          a_nxt = a_cmd;
          d_nxt = {8'h00, flash_host_pkg::D_UNLOCK1};
        end
        3'd1: begin
          a_nxt = a_unl;
          d_nxt = {8'h00, flash_host_pkg::D_UNLOCK2};
        end
        default: begin
          a_nxt = a_cmd;
          d_nxt = {8'h00, (op == flash_host_pkg::OP_SEC_ENTER) ? flash_host_pkg::D_SECURE :
                   flash_host_pkg::D_AUTOSEL};
          l_nxt = (op != flash_host_pkg::OP_SEC_EXIT);
        end
      endcase
    end else if (op == flash_host_pkg::OP_SEC_EXIT) begin
      d_nxt = {8'h00, flash_host_pkg::D_EXIT};
    end else if (op == flash_host_pkg::OP_RESET) begin
      d_nxt = {8'h00, flash_host_pkg::D_RESET};
    end else if (op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_POLL) begin
      w_nxt = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 24'h00_0000;
      data_r <= 16'h0000;
      write_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce) begin
      addr_r <= a_nxt;
      data_r <= d_nxt;
      write_r <= w_nxt;
      last_r <= l_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/flash_host.sv ----
// apb-controlled host that drives a parallel nor flash bus
// assumes flash pins synchronous to pclk; data bus split into in/out/enable
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n
);
  // ******************************
  // apb registers
  // ******************************
  logic [23:0] addr_reg_r;
  logic [15:0] wdata_reg_r;
  logic [15:0] rdata_r;
  logic byte_mode_r;
  logic hw_reset_r;
  logic [3:0] op_r;
  logic busy_r;
  logic done_r;
  logic pass_r;
  logic fail_r;
  logic secure_mode_r;
  logic sec_locked_r;
  logic sec_prot_r;
  logic wr_en;
  logic rd_en;
  logic start;
  logic hit;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~pwrite;
  assign hit = (paddr == flash_host_pkg::OFS_CMD) || (paddr == flash_host_pkg::OFS_ADDR) ||
               (paddr == flash_host_pkg::OFS_WDATA) || (paddr == flash_host_pkg::OFS_STATUS) ||
               (paddr == flash_host_pkg::OFS_RDATA) || (paddr == flash_host_pkg::OFS_MODE);
  assign start = wr_en & (paddr == flash_host_pkg::OFS_CMD) & ~busy_r & (pwdata[3:0] != 4'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        flash_host_pkg::OFS_CMD: prdata = {28'h000_0000, op_r};
        flash_host_pkg::OFS_ADDR: prdata = {8'h00, addr_reg_r};
        flash_host_pkg::OFS_WDATA: prdata = {16'h0000, wdata_reg_r};
        flash_host_pkg::OFS_STATUS: prdata = {25'h000_0000, sec_prot_r, sec_locked_r,
          secure_mode_r, fail_r, pass_r, done_r, busy_r};
        flash_host_pkg::OFS_RDATA: prdata = {16'h0000, rdata_r};
        flash_host_pkg::OFS_MODE: prdata = {30'h0000_0000, hw_reset_r, byte_mode_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg_r <= 24'h00_0000;
      wdata_reg_r <= 16'h0000;
      byte_mode_r <= 1'b0;
      hw_reset_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == flash_host_pkg::OFS_ADDR) addr_reg_r <= pwdata[23:0];
      if (paddr == flash_host_pkg::OFS_WDATA) wdata_reg_r <= pwdata[15:0];
      if (paddr == flash_host_pkg::OFS_MODE) byte_mode_r <= pwdata[0];
      if (paddr == flash_host_pkg::OFS_MODE) hw_reset_r <= pwdata[1];
    end
  end
  // ******************************
  // bus-cycle sequencer
  // ******************************
  flash_host_pkg::seq_state_t state_r;
  flash_host_pkg::seq_state_t state_nxt;
  logic [2:0] idx_r;
  logic [3:0] cnt_r;
  logic [23:0] rom_addr;
  logic [15:0] rom_data;
  logic rom_write;
  logic rom_last;
  logic cnt_done;
  logic toggling;
  logic [15:0] prev_r;
  logic sel_idx_lock;
  logic sel_idx_verify;
  logic poll_first_r;
  logic [3:0] op_nxt;
  logic [2:0] idx_nxt;
  // table is registered: feed it next op and index so it lines up with setup
  assign op_nxt = start ? pwdata[3:0] : op_r;
  assign idx_nxt = start ? 3'd0 :
                   (state_r == flash_host_pkg::S_NEXT) ? idx_r + 3'd1 : idx_r;
  seq_rom u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .op(op_nxt),
    .idx(idx_nxt),
    .byte_mode(byte_mode_r),
    .user_addr(addr_reg_r),
    .user_data(wdata_reg_r),
    .addr_r(rom_addr),
    .data_r(rom_data),
    .write_r(rom_write),
    .last_r(rom_last)
  );
  assign cnt_done = (cnt_r == flash_host_pkg::PULSE_CYC_W);
  // first poll read has nothing to compare with, so it always repeats
  assign toggling = poll_first_r |
                    (prev_r[flash_host_pkg::TOGGLE_BIT] != flash_dq_in[flash_host_pkg::TOGGLE_BIT]);
  assign sel_idx_lock = (addr_reg_r[7:0] == (byte_mode_r ? flash_host_pkg::A_SEC_LOCK_B :
                         flash_host_pkg::A_SEC_LOCK_W));
  assign sel_idx_verify = (addr_reg_r[7:0] == (byte_mode_r ? flash_host_pkg::A_VERIFY_B :
                           flash_host_pkg::A_VERIFY_W));
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      flash_host_pkg::S_IDLE: if (start) state_nxt = flash_host_pkg::S_SETUP;
      flash_host_pkg::S_SETUP: state_nxt = flash_host_pkg::S_STROBE;
      flash_host_pkg::S_STROBE: if (cnt_done) state_nxt = flash_host_pkg::S_HOLD;
      flash_host_pkg::S_HOLD: begin
        if (op_r == flash_host_pkg::OP_POLL && toggling) state_nxt = flash_host_pkg::S_SETUP;
        else if (rom_last) state_nxt = flash_host_pkg::S_DONE;
        else state_nxt = flash_host_pkg::S_NEXT;
      end
      flash_host_pkg::S_NEXT: state_nxt = flash_host_pkg::S_SETUP;
      flash_host_pkg::S_DONE: state_nxt = flash_host_pkg::S_IDLE;
      default: state_nxt = flash_host_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= flash_host_pkg::S_IDLE;
      idx_r <= 3'd0;
      cnt_r <= 4'h0;
      op_r <= 4'h0;
      prev_r <= 16'h0000;
      poll_first_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= (state_r == flash_host_pkg::S_STROBE) ? cnt_r + 4'h1 : 4'h0;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      if (start) poll_first_r <= 1'b1;
      else if (state_r == flash_host_pkg::S_HOLD) poll_first_r <= 1'b0;
      if (state_r == flash_host_pkg::S_HOLD) prev_r <= flash_dq_in;
    end
  end
  // ******************************
  // results and flash pins
  // ******************************
  logic [7:0] st_byte;
  assign st_byte = flash_dq_in[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pass_r <= 1'b0;
      fail_r <= 1'b0;
      secure_mode_r <= 1'b0;
      sec_locked_r <= 1'b0;
      sec_prot_r <= 1'b0;
      rdata_r <= 16'h0000;
      flash_addr <= 24'h00_0000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_reset_n <= 1'b0;
    end else if (clk_en) begin
      flash_reset_n <= ~hw_reset_r;
      if (start) begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
      end
      if (state_r == flash_host_pkg::S_SETUP) begin
        flash_addr <= rom_addr;
        flash_dq_out <= rom_data;
        flash_dq_oe <= rom_write;
        flash_ce_n <= 1'b0;
      end
      if (state_r == flash_host_pkg::S_STROBE) begin
        flash_we_n <= ~rom_write;
        flash_oe_n <= rom_write;
      end
      if (state_r == flash_host_pkg::S_HOLD) begin
        flash_we_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_ce_n <= 1'b1;
        flash_dq_oe <= 1'b0;
        if (!rom_write) rdata_r <= flash_dq_in;
        if (op_r == flash_host_pkg::OP_POLL && !toggling) begin
          pass_r <= (st_byte == flash_host_pkg::ST_PROG_OK) ||
                    (st_byte == flash_host_pkg::ST_ERASE_OK);
          fail_r <= (st_byte != flash_host_pkg::ST_PROG_OK) &&
                    (st_byte != flash_host_pkg::ST_ERASE_OK);
        end
        if (op_r == flash_host_pkg::OP_READ && sel_idx_lock)
          sec_locked_r <= flash_dq_in[flash_host_pkg::INDICATOR_BIT];
        if (op_r == flash_host_pkg::OP_READ && sel_idx_verify)
          sec_prot_r <= flash_dq_in[0];
      end
      if (state_r == flash_host_pkg::S_DONE) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        if (op_r == flash_host_pkg::OP_SEC_ENTER) secure_mode_r <= 1'b1;
        if (op_r == flash_host_pkg::OP_SEC_EXIT || op_r == flash_host_pkg::OP_RESET)
          secure_mode_r <= 1'b0;
      end
      // hardware reset wins over a secure entry ending in the same cycle
      if (hw_reset_r) secure_mode_r <= 1'b0;
    end
  end
  // ******************************
  // checks
  // ******************************
  AST_WE_NOT_OE: assert property (@(posedge pclk) disable iff (!presetn)
    !(!flash_we_n && !flash_oe_n)) else $error("we and oe low together");
  AST_STROBE_CE: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_we_n |-> !flash_ce_n && flash_dq_oe) else $error("write strobe outside ce");
  AST_SEC_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !hw_reset_r && state_r == flash_host_pkg::S_DONE &&
    op_r == flash_host_pkg::OP_SEC_ENTER
    |=> secure_mode_r) else $error("secure mode not set");
  AST_SEC_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && hw_reset_r |=> !secure_mode_r) else $error("secure mode kept over reset");
  AST_POLL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fail_r) |-> $past(st_byte) > flash_host_pkg::ST_ERASE_OK) else $error("bad fail");
  AST_WE_PULSE: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
    $fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n) else $error("write pulse length");
  AST_ADDR_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved in bus cycle");
endmodule
`default_nettype wire

// ---- tb/flash_model.sv ----
// behavioural parallel nor flash answering the host bus cycles
// assumes pins sampled on pclk; bench sets byte mode, poll start and status
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter logic FACTORY = 1'b1
) (
  input wire logic pclk,
  input wire logic byte_mode,
  input wire logic go,
  input wire logic [7:0] stat,
  input wire logic [23:0] a,
  input wire logic [15:0] d,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rst_n,
  output logic [15:0] q
);
  logic [1:0] mode_r;
  logic [1:0] step_r;
  logic [2:0] tog_r;
  logic tbit_r, poll_r, pce, pwe, poe;
  logic [15:0] last_r, rd, wd;
  logic [11:0] wa;
  logic [15:0] nv_guard = 16'hfff7; // sector 3 frozen protected
  logic [15:0] vol_guard = 16'hffdf; // sector 5 set by program 0
  wire [11:0] ca = byte_mode ? 12'haaa : 12'h555;
  wire [11:0] ua = byte_mode ? 12'h555 : 12'h2aa;
  wire [7:0] lo = byte_mode ? {1'b0, a[7:1]} : a[7:0];
  wire prot = ~(nv_guard[a[19:16]] & vol_guard[a[19:16]]);
  wire drv = !ce_n && !oe_n;
  assign q = drv ? rd : ~last_r;
  always_comb begin
    if (poll_r) rd = (tog_r != 0) ? {9'h0, tbit_r, 6'h0} : {8'h0, stat};
    else if (mode_r == 2'd1) rd = (lo == 8'h03) ? {8'h0, FACTORY, 7'h1a} :
      (lo == 8'h02) ? {15'h0, prot} : 16'h0;
    else if (mode_r == 2'd2) rd = (a[6:0] < 7'h08) ? (16'h0bc0 | {13'h0, a[2:0]}) :
      16'hffff;
    else rd = a[15:0] ^ 16'h5a5a;
  end
  always @(posedge pclk) begin
    pce <= ce_n;
    pwe <= we_n;
    poe <= oe_n;
    if (drv) last_r <= rd;
    if (!ce_n && !we_n) begin
      wa <= a[11:0];
      wd <= d;
    end
    if (!pce && !poe && oe_n && tog_r != 0) begin
      tog_r <= tog_r - 3'd1;
      tbit_r <= ~tbit_r;
    end
    if (go) begin
      tog_r <= 3'd3;
      tbit_r <= 1'b0;
      poll_r <= 1'b1;
    end
    if (!rst_n) begin
      mode_r <= 2'd0;
      step_r <= 2'd0;
      poll_r <= 1'b0;
      tog_r <= 3'd0;
    end else if (!pce && !pwe && we_n) begin
      poll_r <= 1'b0;
      step_r <= 2'd0;
      if (wd[7:0] == 8'hf0) mode_r <= 2'd0;
      else if (step_r == 2'd0 && wd[7:0] == 8'haa && wa == ca) step_r <= 2'd1;
      else if (step_r == 2'd1 && wd[7:0] == 8'h55 && wa == ua) step_r <= 2'd2;
      else if (step_r == 2'd2 && wa == ca && wd[7:0] == 8'h90) begin
        if (mode_r == 2'd2) step_r <= 2'd3;
        else mode_r <= 2'd1;
      end else if (step_r == 2'd2 && wa == ca && wd[7:0] == 8'h88) mode_r <= 2'd2;
      else if (step_r == 2'd3 && wd[7:0] == 8'h00) mode_r <= 2'd0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the apb flash host against a flash model
// assumes the flash model beside it and the host package
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] flash_addr, ad;
  logic [15:0] flash_dq_out, flash_dq_in, q;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
  logic byte_mode, go;
  logic [7:0] stat;
  logic [7:0] pv [4] = '{8'h00, 8'h01, 8'h02, 8'h41};
  int fails, comparisons, cycles, seed, i;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : q;
  flash_host dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n));
  flash_model #(.FACTORY(1'b1)) partner (.pclk(pclk), .byte_mode(byte_mode), .go(go),
    .stat(stat), .a(flash_addr), .d(flash_dq_out), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .rst_n(flash_reset_n), .q(q));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ******************************
  // shared tasks
  // ******************************
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [23:0] adr);
    apb(1'b1, flash_host_pkg::OFS_ADDR, {8'h0, adr});
    apb(1'b1, flash_host_pkg::OFS_CMD, {28'h0, c});
    do apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
    chk({31'h0, rd[1]}, 32'h1, "done flag");
  endtask
  task automatic rdw(input logic [23:0] adr, input logic [15:0] exp);
    op(flash_host_pkg::OP_READ, adr);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    chk(rd, {16'h0, exp}, "read word");
  endtask
  function automatic logic [15:0] arr(input logic [23:0] x);
    return x[15:0] ^ 16'h5a5a;
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      results();
    end
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    seed = 10338;
    {psel, penable, pwrite, go, byte_mode, presetn} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    clk_en = 1'b1;
    stat = 8'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk(rd, flash_host_pkg::STATUS_RST, "status after reset");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    for (i = 0; i < 4; i++) begin
      ad = 24'($random(seed));
      rdw(ad, arr(ad));
    end
    apb(1'b1, flash_host_pkg::OFS_CMD, {28'h0, flash_host_pkg::OP_READ});
    clk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "frozen busy");
    clk_en <= 1'b1;
    do apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    chk(rd, {16'h0, arr(ad)}, "read after freeze");
    op(flash_host_pkg::OP_AUTOSEL, 24'h0);
    rdw(24'h00_0003, 16'h009a);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[5]}, 32'h1, "indicator");
    rdw(24'h03_0002, 16'h0001);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[6]}, 32'h1, "verify flag set");
    rdw(24'h05_0002, 16'h0001);
    rdw(24'h01_0002, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[6]}, 32'h0, "verify flag clear");
    op(flash_host_pkg::OP_RESET, 24'h0);
    rdw(ad, arr(ad));
    op(flash_host_pkg::OP_SEC_ENTER, 24'h0);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[4]}, 32'h1, "secure mode on");
    for (i = 0; i < 8; i++) rdw(24'(i), 16'hbc0 | 16'(i));
    rdw(24'h00_0009, 16'hffff);
    op(flash_host_pkg::OP_SEC_EXIT, 24'h0);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[4]}, 32'h0, "secure mode off");
    rdw(ad, arr(ad));
    op(flash_host_pkg::OP_SEC_ENTER, 24'h0);
    apb(1'b1, flash_host_pkg::OFS_MODE, 32'h2);
    apb(1'b1, flash_host_pkg::OFS_MODE, 32'h0);
    rdw(ad, arr(ad));
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[4]}, 32'h0, "secure mode after pin reset");
    byte_mode <= 1'b1;
    apb(1'b1, flash_host_pkg::OFS_MODE, 32'h1);
    op(flash_host_pkg::OP_AUTOSEL, 24'h0);
    rdw(24'h00_0006, 16'h009a);
    rdw(24'h03_0004, 16'h0001);
    op(flash_host_pkg::OP_RESET, 24'h0);
    apb(1'b1, flash_host_pkg::OFS_MODE, 32'h0);
    byte_mode <= 1'b0;
    apb(1'b1, flash_host_pkg::OFS_WDATA, 32'h00aa);
    op(flash_host_pkg::OP_WRITE, 24'h00_0555);
    op(flash_host_pkg::OP_AUTOSEL, 24'h0);
    rdw(24'h00_0003, arr(24'h3));
    op(flash_host_pkg::OP_RESET, 24'h0);
    for (i = 0; i < 4; i++) begin
      stat <= pv[i];
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      op(flash_host_pkg::OP_POLL, 24'h0);
      chk({30'h0, rd[3:2]}, (pv[i] < 8'h02) ? 32'h1 : 32'h2, "poll verdict");
    end
    results();
  end
endmodule
`default_nettype wire
